// ===== fieldbus_master_model.sv
`timescale 1ns/10ps
`include "sync_supervisor_consts.vh"
// ==========================================
// Fieldbus master event source
module fieldbus_master_model (
	// Clock
	input wire core_clk,
	// Event pins, idle low
	output reg [5:0] pins
);
	initial pins = 6'h00;
	// One event: high four cycles, then low four so the next edge is seen
	task pulse(input int i);
		@(posedge core_clk);
		pins[i] <= 1'b1;
		repeat (4) @(posedge core_clk);
		pins[i] <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask
	// One bus cycle; the frame or the output update may be withheld
	task cyc(input int gap, input bit skip, input bit late);
		pulse(`PIN_SYNC0);
		if (!skip) begin
			pulse(`PIN_SM2);
		end
		repeat (gap) @(posedge core_clk);
		pulse(`PIN_SYNC1);
		if (!late) begin
			pulse(`PIN_OUT_DRV);
		end
		pulse(`PIN_IN_SMP);
		pulse(`PIN_IN_AVL);
		repeat (20) @(posedge core_clk);
	endtask
endmodule

// ===== output_sync_supervisor.v
`timescale 1ns/10ps
`include "sync_supervisor_consts.vh"
module output_sync_supervisor #(
	parameter CNT_WIDTH = 16,
	parameter MIN_SPACING_NS = 32'h0000_0000
) (
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Entry access port
	input wire od_req,
	input wire od_write,
	input wire [7:0] od_sub,
	input wire [31:0] od_wdata,
	output reg od_ack_ff,
	output reg od_err_ff,
	output reg [31:0] od_rdata_ff,
	// Event pins from the fieldbus controller
	input wire sm2_evt_pin,
	input wire sync0_pin,
	input wire sync1_pin,
	input wire out_driven_pin,
	input wire in_sampled_pin,
	input wire in_avail_pin,
	input wire operational,
	// Status toward the rest of the device
	output wire local_cycle_start,
	output wire measuring,
	output wire [31:0] in_shift_max,
	output wire [31:0] in_calc_max,
	output wire [31:0] in_delay_max
);
	// ==========================================
	// Pin synchronisers
	wire [`PIN_COUNT-1:0] pin_raw; // Raw pin levels
	reg [`PIN_COUNT-1:0] sync1_ff; // First stage
	reg [`PIN_COUNT-1:0] sync2_ff; // Second stage
	reg [`PIN_COUNT-1:0] sync3_ff; // Third stage
	reg [`PIN_COUNT-1:0] level_ff; // Accepted level
	wire [`PIN_COUNT-1:0] rise; // One-cycle rising events
	reg op_s1_ff; // Operational sync stages
	reg op_s2_ff;
	reg op_s3_ff;
	reg op_ff; // Accepted operational level

	assign pin_raw = {in_avail_pin, in_sampled_pin, out_driven_pin, sync1_pin, sync0_pin, sm2_evt_pin};

	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
			// Accept a change once stages two and three agree
			always @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
					sync3_ff[gi] <= 1'b0;
					level_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
					if (sync2_ff[gi] == sync3_ff[gi]) begin
						level_ff[gi] <= sync3_ff[gi];
					end
				end
			end
			assign rise[gi] = (sync2_ff[gi] == sync3_ff[gi]) && sync3_ff[gi] && !level_ff[gi];
		end
	endgenerate

	// Operational level synchroniser
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_s1_ff <= 1'b0;
			op_s2_ff <= 1'b0;
			op_s3_ff <= 1'b0;
			op_ff <= 1'b0;
		end else begin
			op_s1_ff <= operational;
			op_s2_ff <= op_s1_ff;
			op_s3_ff <= op_s2_ff;
			if (op_s2_ff == op_s3_ff) begin
				op_ff <= op_s3_ff;
			end
		end
	end

	wire sm2_evt = rise[`PIN_SM2];
	wire sync0_evt = rise[`PIN_SYNC0];
	wire sync1_evt = rise[`PIN_SYNC1];
	wire out_drv_evt = rise[`PIN_OUT_DRV];
	wire in_smp_evt = rise[`PIN_IN_SMP];
	wire in_avl_evt = rise[`PIN_IN_AVL];

	// ==========================================
	// Writable entries
	reg [15:0] sync_mode_ff; // Selected sync mode
	reg [31:0] cycle_period_ff; // Cycle period in ns
	reg [15:0] command_ff; // Measurement command
	wire dc_mode; // Distributed-clock mode active
	wire map_hit; // Sub-index exists
	wire ro_hit; // Sub-index is read-only
	wire start_cmd; // Command write of start
	wire wr_ok; // Accepted write

	assign dc_mode = (sync_mode_ff == `MODE_DC_SYNC0) || (sync_mode_ff == `MODE_DC_SYNC1);
	assign map_hit = (od_sub <= `SUB_DELAY_MAX) || (od_sub == `SUB_MISSED_CNT) ||
		(od_sub == `SUB_OVERRUN_CNT) || (od_sub == `SUB_SHORT_CNT) || (od_sub == `SUB_LATE_FLAG);
	assign ro_hit = !((od_sub == `SUB_SYNC_MODE) || (od_sub == `SUB_CYCLE_PERIOD) ||
		(od_sub == `SUB_COMMAND));
	assign wr_ok = od_req && od_write && map_hit && !ro_hit &&
		!((od_sub == `SUB_SYNC_MODE) && (od_wdata[15:0] > `MODE_DC_SYNC1)) &&
		!((od_sub == `SUB_COMMAND) && (od_wdata[15:0] > `CMD_START));
	assign start_cmd = wr_ok && (od_sub == `SUB_COMMAND) && (od_wdata[15:0] == `CMD_START) &&
		(command_ff != `CMD_START);
	assign measuring = (command_ff == `CMD_START);

	// Entry writes; illegal codes are refused
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_mode_ff <= `RST_SYNC_MODE;
			cycle_period_ff <= `RST_CYCLE_PERIOD;
			command_ff <= `RST_COMMAND;
		end else if (wr_ok) begin
			if (od_sub == `SUB_SYNC_MODE) begin
				sync_mode_ff <= od_wdata[15:0];
			end
			if (od_sub == `SUB_CYCLE_PERIOD) begin
				cycle_period_ff <= od_wdata;
			end
			if (od_sub == `SUB_COMMAND) begin
				command_ff <= od_wdata[15:0];
			end
		end
	end

	// ==========================================
	// Time keeping in nanoseconds
	reg [31:0] local_ns_ff; // Free-run timer
	reg [31:0] since_s0_ff; // Time since SYNC0
	reg [31:0] since_s1_ff; // Time since SYNC1
	reg [31:0] since_smp_ff; // Time since inputs sampled
	reg [31:0] since_cyc_ff; // Time since cycle start
	wire free_tick; // Local timer wrap
	reg cyc_start; // Cycle start for selected mode

	assign free_tick = (local_ns_ff + `CLK_PERIOD_NS) >= cycle_period_ff;

	// Cycle start source per mode
	always @* begin
		case (sync_mode_ff)
			`MODE_FREE_RUN: cyc_start = free_tick;
			`MODE_SM2: cyc_start = sm2_evt;
			`MODE_DC_SYNC0: cyc_start = sync0_evt;
			`MODE_DC_SYNC1: cyc_start = sync1_evt;
			default: cyc_start = 1'b0;
		endcase
	end
	assign local_cycle_start = cyc_start;

	// Free-run timer wraps at the cycle period; elapsed-time counters hold at their top value
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_ns_ff <= 32'h0000_0000;
			since_s0_ff <= 32'h0000_0000;
			since_s1_ff <= 32'h0000_0000;
			since_smp_ff <= 32'h0000_0000;
			since_cyc_ff <= 32'h0000_0000;
		end else begin
			local_ns_ff <= free_tick ? 32'h0000_0000 : local_ns_ff + `CLK_PERIOD_NS;
			since_s0_ff <= sync0_evt ? 32'h0000_0000 : sat_add(since_s0_ff);
			since_s1_ff <= sync1_evt ? 32'h0000_0000 : sat_add(since_s1_ff);
			since_smp_ff <= in_smp_evt ? 32'h0000_0000 : sat_add(since_smp_ff);
			since_cyc_ff <= cyc_start ? 32'h0000_0000 : sat_add(since_cyc_ff);
		end
	end

	// Add one clock period without wrapping
	function [31:0] sat_add;
		input [31:0] val;
		begin
			sat_add = (val > (32'hffff_ffff - `CLK_PERIOD_NS)) ? 32'hffff_ffff : val + `CLK_PERIOD_NS;
		end
	endfunction

	// ==========================================
	// Per-cycle bookkeeping
	reg sm2_seen_ff; // SM2 event since last SYNC0
	reg out_done_ff; // Outputs driven this cycle
	reg late_ff; // Outputs late in last cycle
	wire missed_evt;
	wire overrun_evt;
	wire short_evt;

	// SYNC0 without a prior SM event
	assign missed_evt = dc_mode && op_ff && sync0_evt && !sm2_seen_ff;
	assign overrun_evt = op_ff && cyc_start &&
		(!out_done_ff || ((since_cyc_ff + `CLK_PERIOD_NS) < `RST_MIN_CYCLE));
	assign short_evt = dc_mode && sync1_evt && (since_s0_ff < MIN_SPACING_NS);

	// Event bookkeeping; a new event wins over the clear at SYNC0 or at cycle start
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sm2_seen_ff <= 1'b0;
			out_done_ff <= 1'b1;
			late_ff <= 1'b0;
		end else begin
			if (sm2_evt) begin
				sm2_seen_ff <= 1'b1;
			end else if (sync0_evt) begin
				sm2_seen_ff <= 1'b0;
			end
			if (out_drv_evt) begin
				out_done_ff <= 1'b1;
			end else if (cyc_start) begin
				out_done_ff <= 1'b0;
			end
			if (!dc_mode) begin
				late_ff <= 1'b0;
			end else if (cyc_start) begin
				late_ff <= !out_done_ff;
			end
		end
	end

	wire [CNT_WIDTH-1:0] missed_cnt; // Missed SM events
	wire [CNT_WIDTH-1:0] overrun_cnt; // Cycle overruns
	wire [CNT_WIDTH-1:0] short_cnt; // Short sync spacings
	sat_event_counter #(.WIDTH(CNT_WIDTH)) u_missed (.core_clk(core_clk), .sys_rst(sys_rst),
		.event_pulse(missed_evt), .count_ff(missed_cnt));
	sat_event_counter #(.WIDTH(CNT_WIDTH)) u_overrun (.core_clk(core_clk), .sys_rst(sys_rst),
		.event_pulse(overrun_evt), .count_ff(overrun_cnt));
	sat_event_counter #(.WIDTH(CNT_WIDTH)) u_short (.core_clk(core_clk), .sys_rst(sys_rst),
		.event_pulse(short_evt), .count_ff(short_cnt));

	// ==========================================
	// Measurement of peak timing values
	wire [31:0] shift_max; // SYNC0 to outputs
	wire [31:0] cycle_max; // Cycle length
	wire [31:0] spacing_max; // SYNC0 to SYNC1
	wire [31:0] delay_max; // SYNC1 to outputs
	reg min_cyc_clr_ff; // Minimum cycle shows measured value

	// Peak trackers, one per measured interval
	peak_tracker u_shift (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(out_drv_evt), .sample(since_s0_ff), .peak_ff(shift_max));
	peak_tracker u_cycle (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(cyc_start), .sample(since_cyc_ff), .peak_ff(cycle_max));
	peak_tracker u_space (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(sync1_evt), .sample(since_s0_ff), .peak_ff(spacing_max));
	peak_tracker u_delay (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(out_drv_evt), .sample(since_s1_ff), .peak_ff(delay_max));
	peak_tracker u_ishift (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(in_smp_evt), .sample(since_s0_ff), .peak_ff(in_shift_max));
	peak_tracker u_icalc (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(in_avl_evt), .sample(since_smp_ff), .peak_ff(in_calc_max));
	peak_tracker u_idelay (.core_clk(core_clk), .sys_rst(sys_rst), .clear(start_cmd), .enable(measuring),
		.sample_vld(in_smp_evt), .sample(since_s1_ff), .peak_ff(in_delay_max));

	// Minimum cycle shows the fixed figure until a measurement starts
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			min_cyc_clr_ff <= 1'b0;
		end else if (start_cmd) begin
			min_cyc_clr_ff <= 1'b1;
		end
	end

	// ==========================================
	// Entry read mux and answer
	reg [31:0] nxt_rdata;
	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (od_sub)
			`SUB_ENTRY_COUNT: nxt_rdata = {24'h00_0000, `RST_ENTRY_COUNT};
			`SUB_SYNC_MODE: nxt_rdata = {16'h0000, sync_mode_ff};
			`SUB_CYCLE_PERIOD: nxt_rdata = cycle_period_ff;
			`SUB_SHIFT_DELAY: nxt_rdata = dc_mode ? shift_max : 32'h0000_0000;
			`SUB_MODES_SUPPORTED: nxt_rdata = {16'h0000, `VAL_MODES_SUPPORTED};
			`SUB_MIN_CYCLE: nxt_rdata = min_cyc_clr_ff ? cycle_max : `RST_MIN_CYCLE;
			`SUB_SPACING_MIN: nxt_rdata = dc_mode ? spacing_max : 32'h0000_0000;
			`SUB_IN_SAMPLE_MIN: nxt_rdata = dc_mode ? in_delay_max : 32'h0000_0000;
			`SUB_COMMAND: nxt_rdata = {16'h0000, command_ff};
			`SUB_DELAY_MAX: nxt_rdata = dc_mode ? delay_max : 32'h0000_0000;
			`SUB_MISSED_CNT: nxt_rdata = {{(32-CNT_WIDTH){1'b0}}, missed_cnt};
			`SUB_OVERRUN_CNT: nxt_rdata = {{(32-CNT_WIDTH){1'b0}}, overrun_cnt};
			`SUB_SHORT_CNT: nxt_rdata = {{(32-CNT_WIDTH){1'b0}}, short_cnt};
			`SUB_LATE_FLAG: nxt_rdata = {31'h0000_0000, late_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Answer one cycle after each request
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			od_ack_ff <= 1'b0;
			od_err_ff <= 1'b0;
			od_rdata_ff <= 32'h0000_0000;
		end else begin
			od_ack_ff <= od_req;
			od_err_ff <= od_req && !(od_write ? wr_ok : map_hit);
			if (od_req && !od_write) begin
				od_rdata_ff <= nxt_rdata;
			end
		end
	end
endmodule

// ===== peak_tracker.v
`timescale 1ns/10ps
// ==========================================
// Peak tracker: holds the largest sample seen
module peak_tracker #(
	parameter WIDTH = 32
) (
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Control
	input wire clear,
	input wire enable,
	// Sample
	input wire sample_vld,
	input wire [WIDTH-1:0] sample,
	// Result
	output reg [WIDTH-1:0] peak_ff
);
	// Clear wins over a sample in the same cycle
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			peak_ff <= {WIDTH{1'b0}};
		end else if (clear) begin
			peak_ff <= {WIDTH{1'b0}};
		end else if (enable && sample_vld && (sample > peak_ff)) begin
			peak_ff <= sample;
		end
	end
endmodule

// ===== sat_event_counter.v
`timescale 1ns/10ps
// ==========================================
// Saturating event counter
module sat_event_counter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Event
	input wire event_pulse,
	// Count
	output reg [WIDTH-1:0] count_ff
);
	// Sticks at all ones instead of wrapping
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_ff <= {WIDTH{1'b0}};
		end else if (event_pulse && (count_ff != {WIDTH{1'b1}})) begin
			count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ===== sync_supervisor_checker.sv
`timescale 1ns/10ps
`include "sync_supervisor_consts.vh"
// ==========================================
// Entry port and measurement checker
module sync_supervisor_checker (
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Entry access port
	input wire od_req,
	input wire od_write,
	input wire [7:0] od_sub,
	input wire [31:0] od_wdata,
	input wire od_ack_ff,
	input wire od_err_ff,
	input wire [31:0] od_rdata_ff,
	// Measurement status
	input wire measuring,
	input wire [31:0] in_shift_max,
	input wire [31:0] in_calc_max,
	input wire [31:0] in_delay_max
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Decoded requests
	wire rd = od_req & ~od_write;
	wire wr = od_req & od_write;
	wire cmdw = wr & (od_sub == `SUB_COMMAND);
	// ==========================================
	// Entry port timing
	chk_ack_follows: assert property (od_req |=> od_ack_ff)
		else $error("ack missing after request");
	chk_ack_cause: assert property (od_ack_ff |-> $past(od_req))
		else $error("ack without request");
	chk_err_with_ack: assert property (od_err_ff |-> od_ack_ff)
		else $error("error without ack");
	chk_rdata_hold: assert property (!rd |=> $stable(od_rdata_ff))
		else $error("read data changed without read");
	chk_unmapped_read: assert property (rd && od_sub == 8'h0a |=> od_err_ff && od_rdata_ff == 32'h0000_0000)
		else $error("unmapped read not refused");
	// ==========================================
	// Entry contents
	chk_modes_word: assert property (
		rd && od_sub == `SUB_MODES_SUPPORTED |=> od_rdata_ff == 32'h0000_c807 && !od_err_ff)
		else $error("supported modes word wrong");
	chk_modes_ro: assert property (wr && od_sub == `SUB_MODES_SUPPORTED |=> od_err_ff)
		else $error("write to read-only word accepted");
	chk_mode_refused: assert property (
		wr && od_sub == `SUB_SYNC_MODE && od_wdata[15:0] > 16'h0003 |=> od_err_ff)
		else $error("illegal sync mode accepted");
	// ==========================================
	// Measurement control
	chk_cmd_start: assert property (cmdw && od_wdata == 32'h0000_0001 |=> measuring)
		else $error("measurement not started");
	chk_cmd_stop: assert property (cmdw && od_wdata == 32'h0000_0000 |=> !measuring)
		else $error("measurement not stopped");
	chk_peak_clear: assert property (
		cmdw && od_wdata == 32'h0000_0001 && !measuring
		|=> in_shift_max == 32'h0 && in_calc_max == 32'h0 && in_delay_max == 32'h0)
		else $error("peaks not cleared on start");
	chk_peak_hold: assert property (
		!measuring && !cmdw |=> $stable(in_delay_max) && $stable(in_shift_max))
		else $error("peak changed while stopped");
	chk_peak_grow: assert property (measuring && !cmdw |=> in_delay_max >= $past(in_delay_max))
		else $error("peak decreased while measuring");
	// Main scenarios
	cov_start: cover property ($rose(measuring));
	cov_refused: cover property (od_err_ff);
	cov_peak: cover property (measuring && in_delay_max != 32'h0);
endmodule
bind output_sync_supervisor sync_supervisor_checker chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.od_req(od_req), .od_write(od_write), .od_sub(od_sub), .od_wdata(od_wdata), .od_ack_ff(od_ack_ff),
	.od_err_ff(od_err_ff), .od_rdata_ff(od_rdata_ff), .measuring(measuring), .in_shift_max(in_shift_max),
	.in_calc_max(in_calc_max), .in_delay_max(in_delay_max));

// ===== sync_supervisor_consts.vh
`ifndef SYNC_SUPERVISOR_CONSTS_VH
`define SYNC_SUPERVISOR_CONSTS_VH
// ==========================================
// Clock period in nanoseconds (200 MHz)
`define CLK_PERIOD_NS 32'h0000_0005
// ==========================================
// Entry sub-indices
`define SUB_ENTRY_COUNT 8'h00
`define SUB_SYNC_MODE 8'h01
`define SUB_CYCLE_PERIOD 8'h02
`define SUB_SHIFT_DELAY 8'h03
`define SUB_MODES_SUPPORTED 8'h04
`define SUB_MIN_CYCLE 8'h05
`define SUB_SPACING_MIN 8'h06
`define SUB_IN_SAMPLE_MIN 8'h07
`define SUB_COMMAND 8'h08
`define SUB_DELAY_MAX 8'h09
`define SUB_MISSED_CNT 8'h0b
`define SUB_OVERRUN_CNT 8'h0c
`define SUB_SHORT_CNT 8'h0d
`define SUB_LATE_FLAG 8'h20
// ==========================================
// Reset and fixed values
`define RST_ENTRY_COUNT 8'h20
`define RST_SYNC_MODE 16'h0001
`define RST_CYCLE_PERIOD 32'h000f_4240
`define VAL_MODES_SUPPORTED 16'hc807
`define RST_MIN_CYCLE 32'h0001_86a0
`define RST_COMMAND 16'h0000
// ==========================================
// Mode and command codes
`define MODE_FREE_RUN 16'h0000
`define MODE_SM2 16'h0001
`define MODE_DC_SYNC0 16'h0002
`define MODE_DC_SYNC1 16'h0003
`define CMD_STOP 16'h0000
`define CMD_START 16'h0001
// ==========================================
// Input pin indices
`define PIN_SM2 0
`define PIN_SYNC0 1
`define PIN_SYNC1 2
`define PIN_OUT_DRV 3
`define PIN_IN_SMP 4
`define PIN_IN_AVL 5
`define PIN_COUNT 6
`endif

// ===== testbench.sv
`timescale 1ns/10ps
`include "sync_supervisor_consts.vh"
module testbench;
	// ==========================================
	// Signals
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg od_req = 1'b0;
	reg od_write = 1'b0;
	reg [7:0] od_sub = 8'h00;
	reg [31:0] od_wdata = 32'h0000_0000;
	reg operational = 1'b0;
	wire od_ack_ff;
	wire od_err_ff;
	wire measuring;
	wire [31:0] od_rdata_ff;
	wire [31:0] in_shift_max;
	wire [31:0] in_calc_max;
	wire [31:0] in_delay_max;
	wire [5:0] pins;
	int miscompares = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [31:0] v0;
	logic er;
	wire lcs;
	int lcs_cnt = 0;
	int c0;
	always #2.5 core_clk = ~core_clk;
	// Counts cycle-start pulses for the mode checks
	always @(posedge core_clk) begin
		if (lcs === 1'b1) begin
			lcs_cnt <= lcs_cnt + 1;
		end
	end
	// Two-bit counters so saturation is reached in a few cycles; spacing limit 100 ns
	output_sync_supervisor #(.CNT_WIDTH(2), .MIN_SPACING_NS(32'h0000_0064)) uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .od_req(od_req), .od_write(od_write), .od_sub(od_sub),
		.od_wdata(od_wdata), .od_ack_ff(od_ack_ff), .od_err_ff(od_err_ff), .od_rdata_ff(od_rdata_ff),
		.sm2_evt_pin(pins[`PIN_SM2]), .sync0_pin(pins[`PIN_SYNC0]), .sync1_pin(pins[`PIN_SYNC1]),
		.out_driven_pin(pins[`PIN_OUT_DRV]), .in_sampled_pin(pins[`PIN_IN_SMP]),
		.in_avail_pin(pins[`PIN_IN_AVL]), .operational(operational), .local_cycle_start(lcs),
		.measuring(measuring), .in_shift_max(in_shift_max), .in_calc_max(in_calc_max),
		.in_delay_max(in_delay_max));
	fieldbus_master_model fm (.core_clk(core_clk), .pins(pins));
	// ==========================================
	// Compare and access helpers
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task nonzero(input string nm, input logic [31:0] g);
		checks++;
		if (g === 32'h0 || $isunknown(g)) begin
			miscompares++;
			$display("[FAIL] %s expected nonzero seen %h", nm, g);
		end
	endtask
	// Request held one edge; answer sampled one cycle later
	task acc(input logic w, input logic [7:0] s, input logic [31:0] d);
		@(posedge core_clk);
		od_req <= 1'b1;
		od_write <= w;
		od_sub <= s;
		od_wdata <= d;
		@(posedge core_clk);
		od_req <= 1'b0;
		#1;
		chk("ack", 32'h1, {31'h0, od_ack_ff});
		rd = od_rdata_ff;
		er = od_err_ff;
	endtask
	task rdc(input logic [7:0] s, input logic [31:0] e);
		acc(1'b0, s, 32'h0000_0000);
		chk($sformatf("entry %h", s), e, rd);
		chk("read err", 32'h0, {31'h0, er});
	endtask
	task wrc(input logic [7:0] s, input logic [31:0] d, input logic e);
		acc(1'b1, s, d);
		chk($sformatf("write err %h", s), {31'h0, e}, {31'h0, er});
	endtask
	// ==========================================
	// Scenarios
	// Reset values and map
	task t_defaults;
		logic [7:0] s [0:13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
			8'h0b, 8'h0c, 8'h0d, 8'h20};
		logic [31:0] v [0:13] = '{32'h20, 32'h1, 32'h000f_4240, 32'h0, 32'h0000_c807, 32'h0001_86a0,
			32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 14; i++) begin
			rdc(s[i], v[i]);
		end
		acc(1'b0, 8'h0a, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
	endtask
	task t_modes;
		for (int m = 0; m < 4; m++) begin
			wrc(`SUB_SYNC_MODE, 32'(m), 1'b0);
			rdc(`SUB_SYNC_MODE, 32'(m));
		end
		wrc(`SUB_SYNC_MODE, 32'h0000_0004, 1'b1);
		rdc(`SUB_SYNC_MODE, 32'h0000_0003);
		wrc(`SUB_MODES_SUPPORTED, 32'h0000_0000, 1'b1);
		wrc(`SUB_COMMAND, 32'h0000_0002, 1'b1);
		wrc(`SUB_CYCLE_PERIOD, 32'h0007_a120, 1'b0);
		rdc(`SUB_CYCLE_PERIOD, 32'h0007_a120);
		wrc(`SUB_SYNC_MODE, `MODE_DC_SYNC0, 1'b0);
	endtask
	// Counters, flag, peaks in DC mode
	task t_dc;
		@(posedge core_clk);
		operational <= 1'b1;
		wrc(`SUB_COMMAND, `CMD_START, 1'b0);
		chk("measuring", 32'h1, {31'h0, measuring});
		fm.cyc(30, 0, 0);
		acc(1'b0, `SUB_OVERRUN_CNT, 32'h0);
		v0 = rd;
		fm.cyc(30, 0, 0);
		rdc(`SUB_OVERRUN_CNT, v0 + 32'h1);
		acc(1'b0, `SUB_MISSED_CNT, 32'h0);
		v0 = rd;
		fm.cyc(30, 1, 0);
		fm.cyc(30, 0, 0);
		rdc(`SUB_MISSED_CNT, v0 + 32'h1);
		fm.cyc(30, 0, 1);
		fm.cyc(30, 0, 0);
		rdc(`SUB_LATE_FLAG, 32'h1);
		fm.cyc(30, 0, 0);
		rdc(`SUB_LATE_FLAG, 32'h0);
		acc(1'b0, `SUB_SHORT_CNT, 32'h0);
		v0 = rd;
		fm.cyc(0, 0, 0);
		rdc(`SUB_SHORT_CNT, v0 + 32'h1);
		rdc(`SUB_OVERRUN_CNT, 32'h3);
		acc(1'b0, `SUB_SHIFT_DELAY, 32'h0);
		nonzero("shift delay", rd);
		acc(1'b0, `SUB_SPACING_MIN, 32'h0);
		nonzero("spacing", rd);
		acc(1'b0, `SUB_IN_SAMPLE_MIN, 32'h0);
		nonzero("input sample delay", rd);
		acc(1'b0, `SUB_DELAY_MAX, 32'h0);
		nonzero("output delay max", rd);
		nonzero("input shift peak", in_shift_max);
		nonzero("input calc peak", in_calc_max);
	endtask
	task t_stop;
		wrc(`SUB_COMMAND, `CMD_STOP, 1'b0);
		chk("measuring", 32'h0, {31'h0, measuring});
		v0 = in_delay_max;
		fm.cyc(30, 0, 0);
		chk("held peak", v0, in_delay_max);
		wrc(`SUB_SYNC_MODE, `MODE_SM2, 1'b0);
		rdc(`SUB_SHIFT_DELAY, 32'h0);
		wrc(`SUB_COMMAND, `CMD_START, 1'b0);
		chk("cleared peak", 32'h0, in_delay_max);
		chk("cleared shift", 32'h0, in_shift_max);
		chk("cleared calc", 32'h0, in_calc_max);
	endtask
	// Free-run timer period and SYNC1 cycle start
	task t_free;
		wrc(`SUB_CYCLE_PERIOD, 32'h0000_0064, 1'b0);
		wrc(`SUB_SYNC_MODE, `MODE_FREE_RUN, 1'b0);
		repeat (5) @(posedge core_clk);
		c0 = lcs_cnt;
		repeat (200) @(posedge core_clk);
		chk("free-run starts", 32'h0000_000a, 32'(lcs_cnt - c0));
		wrc(`SUB_SYNC_MODE, `MODE_DC_SYNC1, 1'b0);
		c0 = lcs_cnt;
		fm.cyc(30, 0, 0);
		chk("sync1 starts", 32'h0000_0001, 32'(lcs_cnt - c0));
	endtask
	// ==========================================
	// Verdict, main sequence and watchdog
	task finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_defaults;
		t_modes;
		t_dc;
		t_stop;
		t_free;
		finish_test;
	end
	initial begin
		#100000;
		miscompares++;
		finish_test;
	end
endmodule
